//--- dv/as_alert_summary_properties.sv
// Purpose: Port checker for the alert summary block
// Assumes: Writes use both low lanes
// Notes:   Tiny reference state in helper logic
`timescale 1ns/1ps
module as_chk (
  input wire logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, acq_done, cal_done, irq,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [13:0] cell_adc_over_vector, cell_cmp_over_vector, cell_adc_under_vector, cell_cmp_under_vector,
  input wire logic [5:0]  aux_adc_over_vector, aux_cmp_over_vector, aux_adc_under_vector, aux_cmp_under_vector,
  input wire logic [15:0] cal_result
);
  logic [7:0]  sm;
  logic        fm;
  logic [15:0] mk;
  wire rd = psel && !penable && !pwrite && paddr == 8'h1c;
  wire wr = psel && penable && pwrite;
  function automatic logic bad(input logic [15:0] v);
    return v[15] ? v < 16'hfe00 : v > 16'h01ff;
  endfunction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sm <= 8'h00;
      fm <= 1'b0;
      mk <= 16'h0000;
    end else begin
      if (acq_done) sm <= {|cell_adc_over_vector, |cell_cmp_over_vector, |cell_adc_under_vector,
        |cell_cmp_under_vector, |aux_adc_over_vector, |aux_cmp_over_vector, |aux_adc_under_vector,
        |aux_cmp_under_vector};
      if (cal_done) fm <= bad(cal_result);
      else if (wr && paddr == 8'h48) fm <= bad(pwdata[15:0]);
      if (wr && paddr == 8'h44) mk <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ov; rd |=> {prdata[15:14], prdata[11:10]} == {$past(sm[7:6]), $past(sm[3:2])}; endproperty
  a_ov: assert property (p_ov) else $error("overvoltage summary wrong");
  property p_uv; rd |=> {prdata[13:12], prdata[9:8]} == {$past(sm[5:4]), $past(sm[1:0])}; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage summary wrong");
  property p_cal; rd |=> prdata[4] == $past(fm); endproperty
  a_cal: assert property (p_cal) else $error("cal fault bit wrong");
  property p_map; psel && penable && paddr == 8'h1c |-> pready && !pslverr; endproperty
  a_map: assert property (p_map) else $error("summary access refused");
  property p_ro; wr && paddr == 8'h1c |-> !pslverr; endproperty
  a_ro: assert property (p_ro) else $error("summary write flagged");
  property p_bad; psel && penable && !(paddr inside {8'h1c, 8'h40, 8'h44, 8'h48}) |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access accepted");
  property p_irq_off; mk == 16'h0000 |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
  property p_irq_set; acq_done && |cell_adc_over_vector && !sm[7] && mk[15] |=> irq; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missing on new alert");
endmodule // as_chk
bind as_alert_summary as_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .acq_done(acq_done), .cal_done(cal_done), .irq(irq), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .cell_adc_over_vector(cell_adc_over_vector),
  .cell_cmp_over_vector(cell_cmp_over_vector), .cell_adc_under_vector(cell_adc_under_vector),
  .cell_cmp_under_vector(cell_cmp_under_vector), .aux_adc_over_vector(aux_adc_over_vector),
  .aux_cmp_over_vector(aux_cmp_over_vector), .aux_adc_under_vector(aux_adc_under_vector),
  .aux_cmp_under_vector(aux_cmp_under_vector), .cal_result(cal_result));

//--- dv/as_tb.sv
// Purpose: Directed bench for the alert summary block
// Assumes: Zero-wait slave, still waited on
// Notes:   Vectors go all-ones between acquisitions
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        acq_done = 1'b0, cal_done = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata;
  logic [13:0] co = 14'h0, cco = 14'h0, cu = 14'h0, ccu = 14'h0;
  logic [5:0]  ao = 6'h0, aco = 6'h0, au = 6'h0, acu = 6'h0;
  logic [15:0] cal_result = 16'h0000;
  logic [15:0] cv [4] = '{16'h0200, 16'h01ff, 16'hfdff, 16'hfe00};
  wire  [31:0] prdata;
  wire  [15:0] cal_val;
  wire         pready, pslverr, irq;
  int          error_cnt = 0, check_count = 0;
  as_alert_summary i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acq_done(acq_done), .cell_adc_over_vector(co), .cell_cmp_over_vector(cco), .cell_adc_under_vector(cu),
    .cell_cmp_under_vector(ccu), .aux_adc_over_vector(ao), .aux_cmp_over_vector(aco),
    .aux_adc_under_vector(au), .aux_cmp_under_vector(acu), .cal_done(cal_done), .cal_result(cal_result),
    .adc_offset_cal_value(cal_val), .irq(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic acq(input logic [7:0] g, input logic [13:0] c, input logic [5:0] x);
    co <= g[7] ? c : 14'h0;
    cco <= g[6] ? c : 14'h0;
    cu <= g[5] ? c : 14'h0;
    ccu <= g[4] ? c : 14'h0;
    ao <= g[3] ? x : 6'h0;
    aco <= g[2] ? x : 6'h0;
    au <= g[1] ? x : 6'h0;
    acu <= g[0] ? x : 6'h0;
    acq_done <= 1'b1;
    @(posedge clk) acq_done <= 1'b0;
    {co, cco, cu, ccu, ao, aco, au, acu} <= '1;
    @(posedge clk);
  endtask
  task automatic cal(input logic [15:0] v);
    cal_result <= v;
    cal_done <= 1'b1;
    @(posedge clk) cal_done <= 1'b0;
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  // Run needs about 120 cycles
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, 8'h1c, 0); chk("summary reset", rdata, 32'h0);
    for (int i = 0; i < 8; i++) begin
      acq(8'h80 >> i, 14'h2000, 6'h20);
      apb(0, 8'h1c, 0); chk("summary bit", rdata, 32'h8000 >> i);
    end
    acq(8'hff, 14'h2001, 6'h21);
    acq(8'hff, 14'h0001, 6'h01);
    apb(0, 8'h1c, 0); chk("partial resolve", rdata, 32'hff00);
    apb(1, 8'h1c, 32'h0); chk("summary write err", err, 0);
    apb(0, 8'h1c, 0); chk("summary kept", rdata, 32'hff00);
    acq(8'hff, 14'h0, 6'h0);
    apb(0, 8'h1c, 0); chk("all resolved", rdata, 32'h0);
    apb(0, 8'h50, 0); chk("unmapped err", err, 1);
    foreach (cv[i]) begin
      cal(cv[i]);
      apb(0, 8'h1c, 0); chk("cal fault", rdata, (i % 2) ? 32'h0 : 32'h10);
    end
    cal(16'h0300);
    apb(1, 8'h48, 32'h0005); chk("cal value out", cal_val, 32'h5);
    apb(0, 8'h48, 0); chk("cal value read", rdata, 32'h5);
    apb(0, 8'h1c, 0); chk("cal write clears", rdata, 32'h0);
    apb(1, 8'h40, 32'hffff);
    apb(1, 8'h44, 32'h8000); chk("irq idle", irq, 0);
    acq(8'h80, 14'h0001, 6'h0); chk("irq set", irq, 1);
    apb(0, 8'h40, 0); chk("status", rdata, 32'h8000);
    apb(1, 8'h44, 0); chk("irq masked", irq, 0);
    apb(1, 8'h44, 32'h8000); chk("irq unmasked", irq, 1);
    apb(1, 8'h40, 32'h8000); chk("irq cleared", irq, 0);
    report_and_stop;
  end
endmodule // tb

//--- verilog/as_alert_summary.v
// Purpose: Alert summary register with APB slave and interrupt
// Assumes: Scan engine supplies gated alert vectors and strobes
// Notes:   Zero-wait APB; read data captured in the setup cycle
`timescale 1ns/1ps
`include "as_defines.vh"

module as_alert_summary (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`AS_ADDR_W-1:0]  paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Scan engine: acquisition strobe and alert vectors
  input  wire                   acq_done,
  input  wire [`AS_CELL_N-1:0]  cell_adc_over_vector,
  input  wire [`AS_CELL_N-1:0]  cell_cmp_over_vector,
  input  wire [`AS_CELL_N-1:0]  cell_adc_under_vector,
  input  wire [`AS_CELL_N-1:0]  cell_cmp_under_vector,
  input  wire [`AS_AUX_N-1:0]   aux_adc_over_vector,
  input  wire [`AS_AUX_N-1:0]   aux_cmp_over_vector,
  input  wire [`AS_AUX_N-1:0]   aux_adc_under_vector,
  input  wire [`AS_AUX_N-1:0]   aux_cmp_under_vector,
  // Scan engine: offset calibration result
  input  wire                   cal_done,
  input  wire [`AS_REG_W-1:0]   cal_result,
  // Calibration value for the ADC path
  output wire [`AS_REG_W-1:0]   adc_offset_cal_value,
  // Interrupt
  output wire                   irq
);

  // Bus decode
  wire                          setup_phase;
  wire                          access_phase;
  wire                          wr_access;
  wire                          hit_summary;
  wire                          hit_status;
  wire                          hit_mask;
  wire                          hit_cal;
  wire                          hit_any;

  // Summary bits
  wire [`AS_CELL_N*`AS_GROUP_N-1:0] group_vec;
  wire [`AS_GROUP_N-1:0]        group_sum;
  wire [`AS_GROUP_N-1:0]        group_rise;

  // Named summary bits, one per alert group, and the cal fault rise
  wire                          cell_adc_over_summary;
  wire                          cell_cmp_over_summary;
  wire                          cell_adc_under_summary;
  wire                          cell_cmp_under_summary;
  wire                          aux_adc_over_summary;
  wire                          aux_cmp_over_summary;
  wire                          aux_adc_under_summary;
  wire                          aux_cmp_under_summary;
  wire                          cal_fault_rise;

  // One-hot read select, one bit per mapped register
  localparam [3:0]              SEL_SUMMARY = 4'b0001;
  localparam [3:0]              SEL_STATUS  = 4'b0010;
  localparam [3:0]              SEL_MASK    = 4'b0100;
  localparam [3:0]              SEL_CAL     = 4'b1000;
  wire [3:0]                    rd_sel;

  // Calibration
  reg  [`AS_REG_W-1:0]          cal_value;
  reg                           adc_offset_cal_fault;
  reg                           next_cal_fault;
  wire                          cal_wr;
  wire                          hw_cal_ok;
  wire                          sw_cal_ok;

  // Register image and interrupt state
  wire [`AS_REG_W-1:0]          alert_summary;
  wire [`AS_REG_W-1:0]          events;
  reg  [`AS_REG_W-1:0]          int_status;
  reg  [`AS_REG_W-1:0]          int_mask;
  wire [`AS_REG_W-1:0]          status_w1c;
  wire [`AS_REG_W-1:0]          wdata16;
  reg  [31:0]                   next_prdata;

  // In-bounds test of a signed 16-bit offset
  function in_bounds;
    input [`AS_REG_W-1:0] v;
    begin
      in_bounds = ($signed(v) >= $signed(`AS_CAL_MIN)) &&
                  ($signed(v) <= $signed(`AS_CAL_MAX));
    end
  endfunction

  // ---- APB decode

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite;

  assign hit_summary = (paddr == `AS_ADDR_ALERT_SUMMARY);
  assign hit_status  = (paddr == `AS_ADDR_INT_STATUS);
  assign hit_mask    = (paddr == `AS_ADDR_INT_MASK);
  assign hit_cal     = (paddr == `AS_ADDR_CAL_VALUE);
  assign hit_any     = hit_summary | hit_status | hit_mask | hit_cal;

  // No wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  // Low two lanes carry the 16-bit registers; upper lanes ignored
  assign wdata16 = {pstrb[1] ? pwdata[15:8] : `AS_ZERO_PAD,
                    pstrb[0] ? pwdata[7:0]  : `AS_ZERO_PAD};

  // ---- Summary bits, one instance per alert group

  // Aux vectors zero-padded to the cell width so one loop serves all
  assign group_vec = {
    cell_adc_over_vector,
    cell_cmp_over_vector,
    cell_adc_under_vector,
    cell_cmp_under_vector,
    {(`AS_CELL_N-`AS_AUX_N){1'b0}}, aux_adc_over_vector,
    {(`AS_CELL_N-`AS_AUX_N){1'b0}}, aux_cmp_over_vector,
    {(`AS_CELL_N-`AS_AUX_N){1'b0}}, aux_adc_under_vector,
    {(`AS_CELL_N-`AS_AUX_N){1'b0}}, aux_cmp_under_vector
  };

  genvar g;
  generate
    for (g = 0; g < `AS_GROUP_N; g = g + 1) begin : gen_sum
      as_summary_bit u_sum (
        .clk          (clk),
        .rst_n        (rst_n),
        .acq_done     (acq_done),
        .alert_vector (group_vec[g*`AS_CELL_N +: `AS_CELL_N]),
        .summary      (group_sum[g]),
        .summary_rise (group_rise[g])
      );
    end
  endgenerate

  // ---- Offset calibration value and fault

  // Software write re-checks the new value, as a calibration would
  assign cal_wr    = wr_access & hit_cal;
  assign hw_cal_ok = in_bounds(cal_result);
  assign sw_cal_ok = in_bounds(wdata16);

  always @(posedge clk) begin
    if (!rst_n) begin
      cal_value <= `AS_CAL_RST;
    end else if (cal_wr) begin
      cal_value <= wdata16;
    end else if (cal_done) begin
      cal_value <= cal_result;
    end
  end

  assign adc_offset_cal_value = cal_value;

  // Hardware result has priority over a same-cycle software write for the fault bit; cal_value takes the write
  always @* begin
    next_cal_fault = adc_offset_cal_fault;
    if (cal_done) begin
      next_cal_fault = ~hw_cal_ok;
    end else if (cal_wr) begin
      next_cal_fault = ~sw_cal_ok;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      adc_offset_cal_fault <= 1'b0;
    end else begin
      adc_offset_cal_fault <= next_cal_fault;
    end
  end

  // ---- Register image

  // Unused bits of the low byte read as zero
  // Group order in group_vec puts cell ADC overvoltage at the top
  assign cell_adc_over_summary  = group_sum[`AS_BIT_CELL_ADC_OVER  - `AS_SUM_LSB];
  assign cell_cmp_over_summary  = group_sum[`AS_BIT_CELL_CMP_OVER  - `AS_SUM_LSB];
  assign cell_adc_under_summary = group_sum[`AS_BIT_CELL_ADC_UNDER - `AS_SUM_LSB];
  assign cell_cmp_under_summary = group_sum[`AS_BIT_CELL_CMP_UNDER - `AS_SUM_LSB];
  assign aux_adc_over_summary   = group_sum[`AS_BIT_AUX_ADC_OVER   - `AS_SUM_LSB];
  assign aux_cmp_over_summary   = group_sum[`AS_BIT_AUX_CMP_OVER   - `AS_SUM_LSB];
  assign aux_adc_under_summary  = group_sum[`AS_BIT_AUX_ADC_UNDER  - `AS_SUM_LSB];
  assign aux_cmp_under_summary  = group_sum[`AS_BIT_AUX_CMP_UNDER  - `AS_SUM_LSB];

  // Unused bits of the low byte read as zero
  assign alert_summary = {
    cell_adc_over_summary,
    cell_cmp_over_summary,
    cell_adc_under_summary,
    cell_cmp_under_summary,
    aux_adc_over_summary,
    aux_cmp_over_summary,
    aux_adc_under_summary,
    aux_cmp_under_summary,
    3'b000,
    adc_offset_cal_fault,
    4'h0
  };

  // ---- Interrupt: sticky status, write one to clear, mask gates irq

  // Only a new fault raises status; a fault that persists does not re-fire
  assign cal_fault_rise = next_cal_fault & ~adc_offset_cal_fault;

  assign events = {
    group_rise,
    3'b000,
    cal_fault_rise,
    4'h0
  };

  assign status_w1c = (wr_access & hit_status) ? wdata16 : `AS_RST_16;

  // A new event in the clearing cycle wins over the clear
  always @(posedge clk) begin
    if (!rst_n) begin
      int_status <= `AS_RST_16;
    end else begin
      int_status <= ((int_status & ~status_w1c) | events) & `AS_IMPL_MASK;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      int_mask <= `AS_RST_16;
    end else if (wr_access & hit_mask) begin
      int_mask <= wdata16 & `AS_IMPL_MASK;
    end
  end

  assign irq = |(int_status & int_mask);

  // ---- Read path

  // Address decodes are exclusive, so the select is one-hot or zero
  assign rd_sel = {hit_cal, hit_mask, hit_status, hit_summary};

  // Summary register has no write decode at all; writes fall through
  always @* begin
    next_prdata = `AS_RST_32;
    case (rd_sel)
      SEL_SUMMARY: begin
        next_prdata[`AS_REG_W-1:0] = alert_summary;
      end
      SEL_STATUS: begin
        next_prdata[`AS_REG_W-1:0] = int_status;
      end
      SEL_MASK: begin
        next_prdata[`AS_REG_W-1:0] = int_mask;
      end
      SEL_CAL: begin
        next_prdata[`AS_REG_W-1:0] = cal_value;
      end
      default: begin
        // Unmapped reads return zero alongside the error response
        next_prdata = `AS_RST_32;
      end
    endcase
  end

  // Captured at setup so prdata is a flop during the access cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= `AS_RST_32;
    end else if (setup_phase & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule // as_alert_summary

//--- verilog/as_defines.vh
// Purpose: Constants for the alert summary register block
// Assumes: 40 MHz clk, APB with 32-bit data
// Notes:   Offsets are byte addresses on the APB side
`ifndef AS_DEFINES_VH
`define AS_DEFINES_VH

// Printed register index and its byte address
`define AS_IDX_ALERT_SUMMARY  8'h07
`define AS_ADDR_ALERT_SUMMARY 8'h1c
// Block-local registers
`define AS_ADDR_INT_STATUS    8'h40
`define AS_ADDR_INT_MASK      8'h44
`define AS_ADDR_CAL_VALUE     8'h48

// Field positions in alert_summary (and in status/mask)
`define AS_BIT_CELL_ADC_OVER  15
`define AS_BIT_CELL_CMP_OVER  14
`define AS_BIT_CELL_ADC_UNDER 13
`define AS_BIT_CELL_CMP_UNDER 12
`define AS_BIT_AUX_ADC_OVER   11
`define AS_BIT_AUX_CMP_OVER   10
`define AS_BIT_AUX_ADC_UNDER  9
`define AS_BIT_AUX_CMP_UNDER  8
`define AS_BIT_CAL_FAULT      4
`define AS_SUM_LSB            8
`define AS_SUM_MSB            15

// Widths and counts
`define AS_REG_W      16
`define AS_CELL_N     14
`define AS_AUX_N      6
`define AS_GROUP_N    8
`define AS_ADDR_W     8

// Reset values and masks
`define AS_RST_16     16'h0000
`define AS_RST_32     32'h0000_0000
`define AS_IMPL_MASK  16'hff10
`define AS_ZERO_PAD   8'h00

// Offset calibration window, signed two's complement
`define AS_CAL_MIN    16'hfe00
`define AS_CAL_MAX    16'h01ff
`define AS_CAL_RST    16'h0000

`endif

//--- verilog/as_summary_bit.v
// Purpose: One summary bit: OR of an alert vector, taken at acquisition
// Assumes: Vector bits already gated by their channel enables
// Notes:   Also reports a one-cycle pulse when the summary rises
`timescale 1ns/1ps
`include "as_defines.vh"

module as_summary_bit (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // Acquisition strobe and vector
  input  wire                   acq_done,
  input  wire [`AS_CELL_N-1:0]  alert_vector,
  // Summary out
  output reg                    summary,
  output wire                   summary_rise
);

  wire next_summary;

  // Whole vector re-evaluated each acquisition; clears only when all resolved
  assign next_summary = acq_done ? (|alert_vector) : summary;
  assign summary_rise = next_summary & ~summary;

  always @(posedge clk) begin
    if (!rst_n) begin
      summary <= 1'b0;
    end else begin
      summary <= next_summary;
    end
  end

endmodule // as_summary_bit
